// File: charger_ctrl.v
/*
 * Battery charger control and status: two 16-bit control registers,
 * mode state machine, monitor gating and charge timeout.
 * Assumes a register access port on mclk, key and state-machine reset
 * from same-clock logic, and analogue status levels arriving from pins.
 */
// Notes on behaviour
// - End of charge in fast charge: zero current or run to timeout
// - Fast charge only when enabled and valid
// - Fast enable held low until ready seen
// - Throttle against USB limit in fast charge
// - Thermistor monitor gates missing-thermistor detection
// - Hot monitor gates over-temperature indication
// - Cold monitor gates under-temperature indication
// - Die monitor gates chip temperature, keyed
// - Active flag only while truly charging
// - Pause suspends charging; cleared by state machine
// - Mode field: off, trickle, fast, reserved
// - Timeout write: 60 to 510 minutes
// - Timeout read returns remaining 2048 s units
// - Wall feedback ignored when masked on line
// - Trickle current select 50 or 100 mA
// - Termination voltage select 4.05 to 4.2 V
// - Fast current limit code, reset 0110
// - Fast current code 50 mA steps, 750 max
// - Key guards writes except pause and the thermistor, hot and cold monitors; state machine resets fields
`timescale 1ns/1ps
`include "charger_regs.vh"

module charger_ctrl #(
	parameter CYCLES_PER_SEC = `SECOND_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Register access port
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	// Same-clock system controls
	input wire key_unlocked,
	input wire sm_reset,
	// Analogue status pins
	input wire fast_charge_ready,
	input wire supply_valid,
	input wire battery_low,
	input wire charge_done,
	input wire thermistor_missing,
	input wire battery_hot,
	input wire battery_cold,
	input wire die_hot,
	input wire wall_supply_feedback,
	input wire line_powered,
	input wire usb_limit_hit,
	// Charger drive
	output reg charge_on_q,
	output reg fast_on_q,
	output reg throttle_q,
	output reg trickle_current_select_q,
	output reg [1:0] termination_voltage_select_q,
	output reg [3:0] fast_current_select_q
);

// State codes
localparam [1:0] ST_OFF = 2'h0;
localparam [1:0] ST_TRICKLE = 2'h1;
localparam [1:0] ST_FAST = 2'h2;
localparam [1:0] ST_DONE = 2'h3;

// Control one fields
reg charger_request_q;
reg end_of_charge_action_q;
reg fast_charge_enable_q;
reg fast_usb_throttle_enable_q;
reg thermistor_monitor_enable_q;
reg battery_hot_monitor_enable_q;
reg battery_cold_monitor_enable_q;
reg die_temp_monitor_enable_q;
// Control two fields
reg charge_pause_q;
reg [3:0] charge_timeout_field_q;
reg wall_feedback_mask_q;
// Internal state
reg fast_ready_seen_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg timer_load_q;
reg [15:0] rd_d;

wire [10:0] pins_q;
wire ready_s;
wire supply_s;
wire low_s;
wire done_s;
wire ntc_s;
wire hot_s;
wire cold_s;
wire die_s;
wire wall_s;
wire line_s;
wire usb_s;
wire wr_one;
wire wr_two;
wire fault;
wire allowed;
wire charging;
wire [14:0] remain_sec;
wire expired;
wire [1:0] mode_sts;

// Mode status encoding from the state
function [1:0] sts_of;
	input [1:0] st;
	begin
		case (st)
			ST_TRICKLE: sts_of = `STS_TRICKLE;
			ST_FAST: sts_of = `STS_FAST;
			default: sts_of = `STS_OFF;
		endcase
	end
endfunction

// Pin inputs cross into mclk through the agreement filter
sync3 #(
	.W(11)
) u_sync (
	.mclk(mclk),
	.rst_n(rst_n),
	.async_in({fast_charge_ready, supply_valid, battery_low, charge_done,
		thermistor_missing, battery_hot, battery_cold, die_hot,
		wall_supply_feedback, line_powered, usb_limit_hit}),
	.sync_q(pins_q)
);

assign {ready_s, supply_s, low_s, done_s, ntc_s, hot_s, cold_s, die_s,
	wall_s, line_s, usb_s} = pins_q;

assign wr_one = reg_wr && (reg_addr == `OFS_CTRL_ONE);
assign wr_two = reg_wr && (reg_addr == `OFS_CTRL_TWO);

// Each temperature fault counts only if its monitor is enabled; wall feedback on line power counts unless masked
assign fault = (thermistor_monitor_enable_q & ntc_s)
	| (battery_hot_monitor_enable_q & hot_s)
	| (battery_cold_monitor_enable_q & cold_s)
	| (die_temp_monitor_enable_q & die_s)
	| (line_s & wall_s & ~wall_feedback_mask_q);

// The request bit alone never starts charging
assign allowed = charger_request_q & supply_s & ~fault & ~charge_pause_q;
assign charging = (state_q == ST_TRICKLE) || (state_q == ST_FAST);
assign mode_sts = sts_of(state_q);

// Timeout counter; runs only during real charging
charge_timer #(
	.CYCLES_PER_SEC(CYCLES_PER_SEC)
) u_timer (
	.mclk(mclk),
	.rst_n(rst_n),
	.load(timer_load_q),
	.code(charge_timeout_field_q),
	.run(charging),
	.remain_q(remain_sec),
	.expired_q(expired)
);

// Control one register; key and state-machine reset
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		charger_request_q <= `RST_REQUEST;
		end_of_charge_action_q <= 1'b0;
		fast_charge_enable_q <= 1'b0;
		fast_usb_throttle_enable_q <= 1'b0;
		thermistor_monitor_enable_q <= `RST_MON;
		battery_hot_monitor_enable_q <= `RST_MON;
		battery_cold_monitor_enable_q <= `RST_MON;
		die_temp_monitor_enable_q <= `RST_MON;
		fast_ready_seen_q <= 1'b0;
	end else if (sm_reset) begin
		// State-machine reset returns its fields to defaults
		charger_request_q <= `RST_REQUEST;
		end_of_charge_action_q <= 1'b0;
		fast_charge_enable_q <= 1'b0;
		fast_usb_throttle_enable_q <= 1'b0;
		fast_ready_seen_q <= fast_ready_seen_q | ready_s;
	end else begin
		fast_ready_seen_q <= fast_ready_seen_q | ready_s;
		if (wr_one) begin
			thermistor_monitor_enable_q <= reg_wdata[`C1_NTC_MON];
			battery_hot_monitor_enable_q <= reg_wdata[`C1_HOT_MON];
			battery_cold_monitor_enable_q <= reg_wdata[`C1_COLD_MON];
		end
		if (wr_one && key_unlocked) begin
			charger_request_q <= reg_wdata[`C1_REQUEST];
			end_of_charge_action_q <= reg_wdata[`C1_END_ACT];
			fast_usb_throttle_enable_q <= reg_wdata[`C1_THROTTLE];
			die_temp_monitor_enable_q <= reg_wdata[`C1_DIE_MON];
			// Writes before the ready indication are dropped
			if (fast_ready_seen_q) begin
				fast_charge_enable_q <= reg_wdata[`C1_FAST];
			end
		end
	end
end

// Control two register; mode and active bits are read-only
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		charge_pause_q <= 1'b0;
		charge_timeout_field_q <= `RST_TIME;
		wall_feedback_mask_q <= 1'b0;
		trickle_current_select_q <= 1'b0;
		termination_voltage_select_q <= `RST_VSEL;
		fast_current_select_q <= `RST_ISEL;
	end else if (sm_reset) begin
		charge_pause_q <= 1'b0;
		wall_feedback_mask_q <= 1'b0;
	end else begin
		if (wr_two) begin
			charge_pause_q <= reg_wdata[`C2_PAUSE];
		end
		if (wr_two && key_unlocked) begin
			charge_timeout_field_q <= reg_wdata[`C2_TIME_HI:`C2_TIME_LO];
			wall_feedback_mask_q <= reg_wdata[`C2_WALL_MASK];
			trickle_current_select_q <= reg_wdata[`C2_TRICKLE];
			termination_voltage_select_q <= reg_wdata[`C2_VSEL_HI:`C2_VSEL_LO];
			// Advice to stay under 400 mA on USB is left to software
			fast_current_select_q <= reg_wdata[`C2_ISEL_HI:`C2_ISEL_LO];
		end
	end
end

// Mode state machine
always @* begin
	state_d = state_q;
	case (state_q)
		ST_OFF: begin
			if (allowed && !expired) begin
				if (!low_s && fast_charge_enable_q) begin
					state_d = ST_FAST;
				end else if (low_s || !done_s) begin
					state_d = ST_TRICKLE;
				end
			end
		end
		ST_TRICKLE: begin
			if (!allowed) begin
				state_d = ST_OFF;
			end else if (expired) begin
				state_d = ST_DONE;
			end else if (!low_s && fast_charge_enable_q) begin
				state_d = ST_FAST;
			end
		end
		ST_FAST: begin
			if (!allowed) begin
				state_d = ST_OFF;
			end else if (expired) begin
				state_d = ST_DONE;
			end else if (!fast_charge_enable_q) begin
				state_d = ST_TRICKLE;
			end else if (done_s && !end_of_charge_action_q) begin
				state_d = ST_DONE;
			end
		end
		ST_DONE: begin
			// Held at zero current until the request is withdrawn
			if (!charger_request_q) begin
				state_d = ST_OFF;
			end
		end
		default: state_d = ST_OFF;
	endcase
	// State-machine reset overrides every transition, so drive outputs drop too
	if (sm_reset) begin
		state_d = ST_OFF;
	end
end

// State, timer load and charger drive outputs
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		state_q <= ST_OFF;
		timer_load_q <= 1'b1;
		charge_on_q <= 1'b0;
		fast_on_q <= 1'b0;
		throttle_q <= 1'b0;
	end else begin
		state_q <= state_d;
		// A new timeout or a fresh cycle reloads the full time
		timer_load_q <= (wr_two && key_unlocked && !sm_reset)
			|| (state_q == ST_DONE && state_d == ST_OFF);
		charge_on_q <= (state_d == ST_TRICKLE) || (state_d == ST_FAST);
		fast_on_q <= (state_d == ST_FAST);
		throttle_q <= (state_d == ST_FAST) && fast_usb_throttle_enable_q && usb_s;
	end
end

// Read data registered one cycle after the strobe
always @* begin
	rd_d = 16'h0000;
	if (reg_addr == `OFS_CTRL_ONE) begin
		rd_d[`C1_REQUEST] = charger_request_q;
		rd_d[`C1_END_ACT] = end_of_charge_action_q;
		rd_d[`C1_FAST] = fast_charge_enable_q;
		rd_d[`C1_THROTTLE] = fast_usb_throttle_enable_q;
		rd_d[`C1_NTC_MON] = thermistor_monitor_enable_q;
		rd_d[`C1_HOT_MON] = battery_hot_monitor_enable_q;
		rd_d[`C1_COLD_MON] = battery_cold_monitor_enable_q;
		rd_d[`C1_DIE_MON] = die_temp_monitor_enable_q;
	end else if (reg_addr == `OFS_CTRL_TWO) begin
		rd_d[`C2_ACTIVE] = charge_on_q;
		rd_d[`C2_PAUSE] = charge_pause_q;
		rd_d[`C2_STS_HI:`C2_STS_LO] = mode_sts;
		// Remaining time, not the written code
		rd_d[`C2_TIME_HI:`C2_TIME_LO] = remain_sec[14:`READ_UNIT_SHIFT];
		rd_d[`C2_WALL_MASK] = wall_feedback_mask_q;
		rd_d[`C2_TRICKLE] = trickle_current_select_q;
		rd_d[`C2_VSEL_HI:`C2_VSEL_LO] = termination_voltage_select_q;
		rd_d[`C2_ISEL_HI:`C2_ISEL_LO] = fast_current_select_q;
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		reg_rdata_q <= 16'h0000;
	end else if (reg_rd) begin
		reg_rdata_q <= rd_d;
	end
end

endmodule

// File: charger_regs.vh
/*
 * Register offsets, field positions, reset values and timing figures
 * of the battery charger control block.
 * Assumes inclusion by bare name from the design files that need it.
 */
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

// Register byte offsets on the control interface
`define OFS_CTRL_ONE 8'ha8
`define OFS_CTRL_TWO 8'ha9

// Control one field positions
`define C1_REQUEST 15
`define C1_END_ACT 6
`define C1_FAST 5
`define C1_THROTTLE 4
`define C1_NTC_MON 3
`define C1_HOT_MON 2
`define C1_COLD_MON 1
`define C1_DIE_MON 0

// Control two field positions
`define C2_ACTIVE 15
`define C2_PAUSE 14
`define C2_STS_HI 13
`define C2_STS_LO 12
`define C2_TIME_HI 11
`define C2_TIME_LO 8
`define C2_WALL_MASK 7
`define C2_TRICKLE 6
`define C2_VSEL_HI 5
`define C2_VSEL_LO 4
`define C2_ISEL_HI 3
`define C2_ISEL_LO 0

// Reset values
`define RST_REQUEST 1'b1
`define RST_MON 1'b1
`define RST_TIME 4'hb
`define RST_ISEL 4'h6
`define RST_VSEL 2'h0

// Mode status codes
`define STS_OFF 2'h0
`define STS_TRICKLE 2'h1
`define STS_FAST 2'h2

// Timeout figures
`define TIMEOUT_BASE_MIN 60
`define TIMEOUT_STEP_MIN 30
`define SEC_PER_MIN 60
`define READ_UNIT_SHIFT 11
`define CLK_PERIOD_NS 10
`define SECOND_NS 1000000000

`endif

// File: sync3.v
/*
 * Three-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous levels; an output bit changes only
 * when the second and third stages agree.
 */
`timescale 1ns/1ps

module sync3 #(
	parameter W = 1
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Raw and clean levels
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_q
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
integer i;

// First stage feeds only the second one
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		s1_q <= {W{1'b0}};
		s2_q <= {W{1'b0}};
		s3_q <= {W{1'b0}};
		sync_q <= {W{1'b0}};
	end else begin
		s1_q <= async_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
		// Agreement filter rejects a single-cycle disagreement
		for (i = 0; i < W; i = i + 1) begin
			if (s2_q[i] == s3_q[i]) begin
				sync_q[i] <= s3_q[i];
			end
		end
	end
end

endmodule

// File: charge_timer.v
/*
 * Charge timeout counter: holds the remaining charge time in seconds.
 * Assumes load and run come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "charger_regs.vh"

module charge_timer #(
	parameter CYCLES_PER_SEC = 100000000
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Control
	input wire load,
	input wire [3:0] code,
	input wire run,
	// State
	output reg [14:0] remain_q,
	output reg expired_q
);

reg [31:0] pre_q;
wire sec_tick;
wire [31:0] load_min;
wire [31:0] load_full;
wire [14:0] load_sec;

// Longest code is 510 min, which fits 15 bits of seconds
assign load_min = {28'h0000000, code} * `TIMEOUT_STEP_MIN + `TIMEOUT_BASE_MIN;
assign load_full = load_min * `SEC_PER_MIN;
assign load_sec = load_full[14:0];
assign sec_tick = (pre_q == CYCLES_PER_SEC - 1);

// Seconds prescaler runs only while charging, so a pause freezes time
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		pre_q <= 32'h0;
		remain_q <= 15'h0;
		expired_q <= 1'b0;
	end else if (load) begin
		pre_q <= 32'h0;
		remain_q <= load_sec;
		expired_q <= 1'b0;
	end else if (run && !expired_q) begin
		pre_q <= sec_tick ? 32'h0 : pre_q + 32'h1;
		if (sec_tick) begin
			remain_q <= remain_q - 15'h1;
			expired_q <= (remain_q == 15'h1);
		end
	end
end

endmodule

// File: charger_ctrl_properties.sv
/* Concurrent checks on the charger control ports.
   Assumes it is bound into charger_ctrl: one clock, asynchronous low reset. */
`timescale 1ns/1ps
module charger_ctrl_properties (
	// Clock and reset
	input logic mclk,
	input logic rst_n,
	// Register port
	input logic [7:0] reg_addr,
	input logic reg_wr,
	input logic reg_rd,
	input logic [15:0] reg_rdata_q,
	// Controls and pins
	input logic key_unlocked,
	input logic sm_reset,
	input logic supply_valid,
	input logic usb_limit_hit,
	// Charger drive
	input logic charge_on_q,
	input logic fast_on_q,
	input logic throttle_q,
	input logic trickle_current_select_q,
	input logic [1:0] termination_voltage_select_q,
	input logic [3:0] fast_current_select_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Drive settings move only after an unlocked write to control two
	isel_keyed_a: assert property ($changed(fast_current_select_q) |->
		$past(reg_wr) && $past(key_unlocked) && $past(reg_addr) == 8'ha9)
		else $error("current select moved");
	trickle_keyed_a: assert property ($changed(trickle_current_select_q) |->
		$past(reg_wr) && $past(key_unlocked) && $past(reg_addr) == 8'ha9)
		else $error("trickle moved");
	vsel_keyed_a: assert property ($changed(termination_voltage_select_q) |->
		$past(reg_wr) && $past(key_unlocked) && $past(reg_addr) == 8'ha9)
		else $error("voltage moved");
	// Status reads never show the reserved mode, and hold between reads
	mode_not_reserved_a: assert property (reg_rd && reg_addr == 8'ha9 |=>
		reg_rdata_q[13:12] != 2'b11) else $error("reserved mode read");
	read_data_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved");
	fast_is_charge_a: assert property (fast_on_q |-> charge_on_q)
		else $error("fast without charge");
	// Pin changes take at most five cycles through the synchroniser
	no_supply_off_a: assert property (!supply_valid [*6] |=> !charge_on_q)
		else $error("charging without supply");
	throttle_cause_a: assert property (!usb_limit_hit [*6] |=> !throttle_q)
		else $error("throttle without limit");
	// Fast bit is cleared, so fast charge cannot follow a state-machine reset
	smr_no_fast_a: assert property (sm_reset |-> ##2 !fast_on_q [*3])
		else $error("fast after reset");
endmodule
bind charger_ctrl charger_ctrl_properties i_props (.*);

// File: battery_model.sv
/* Battery and supply seen from the charger status pins.
   Assumes the bench sets supply, cell and fault states through cmd and faults. */
`timescale 1ns/1ps
module battery_model (
	// Bench settings
	input logic [6:0] cmd,
	input logic [3:0] faults,
	// Charger drive
	input logic fast_on,
	// Status pins
	output logic fast_charge_ready,
	output logic supply_valid,
	output logic battery_low,
	output logic charge_done,
	output logic thermistor_missing,
	output logic battery_hot,
	output logic battery_cold,
	output logic die_hot,
	output logic wall_supply_feedback,
	output logic line_powered,
	output logic usb_limit_hit
);
	// Levels follow the bench; fault order matches the monitor bits
	assign {wall_supply_feedback, line_powered, fast_charge_ready} = cmd[6:4];
	assign {charge_done, battery_low, supply_valid} = cmd[2:0];
	assign {thermistor_missing, battery_hot, battery_cold, die_hot} = faults;
	// A weak USB source only sags while fast current flows
	assign usb_limit_hit = cmd[3] & fast_on;
endmodule

// File: test_charger_ctrl.sv
/* Self-checking bench for the charger control block.
   Assumes the battery model on the pins and a one second tick of ten cycles. */
`timescale 1ns/1ps
module test_charger_ctrl;
	logic mclk, rst_n, reg_wr, reg_rd, key_unlocked, sm_reset;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, d;
	logic [6:0] cmd;
	logic [3:0] faults;
	wire [15:0] reg_rdata_q;
	wire charge_on_q, fast_on_q, throttle_q, trickle_current_select_q;
	wire [1:0] termination_voltage_select_q;
	wire [3:0] fast_current_select_q;
	wire fast_charge_ready, supply_valid, battery_low, charge_done, thermistor_missing;
	wire battery_hot, battery_cold, die_hot, wall_supply_feedback, line_powered, usb_limit_hit;
	wire [2:0] outs = {throttle_q, fast_on_q, charge_on_q};
	int bad_count, num_checks;

	charger_ctrl #(.CYCLES_PER_SEC(10)) i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata_q, .key_unlocked, .sm_reset, .fast_charge_ready, .supply_valid,
		.battery_low, .charge_done, .thermistor_missing, .battery_hot, .battery_cold, .die_hot,
		.wall_supply_feedback, .line_powered, .usb_limit_hit, .charge_on_q, .fast_on_q,
		.throttle_q, .trickle_current_select_q, .termination_voltage_select_q,
		.fast_current_select_q);
	battery_model i_batt (.cmd, .faults, .fast_on(fast_on_q), .fast_charge_ready,
		.supply_valid, .battery_low, .charge_done, .thermistor_missing, .battery_hot,
		.battery_cold, .die_hot, .wall_supply_feedback, .line_powered, .usb_limit_hit);

	// Free-running 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle strobes; the next access waits for a fresh edge
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask

	task rc(input logic [7:0] a, input logic [15:0] exp, input string what);
		rd(a);
		chk(what, d, exp);
	endtask

	// Bounded wait on one charger output; a hang ends the run
	task await(input int s, input logic v, input int n);
		int k;
		for (k = 0; k < n && outs[s] !== v; k++) begin
			@(posedge mclk);
			#1;
		end
		chk("charger output", {15'h0, outs[s]}, {15'h0, v});
		if (outs[s] !== v) report_and_stop();
	endtask

	initial begin
		int i;
		rst_n = 1'b0;
		{reg_wr, reg_rd, key_unlocked, sm_reset} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		cmd = 7'h00;
		faults = 4'h0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rc(8'ha8, 16'h800f, "control one");
		rc(8'ha9, 16'h0b06, "control two");
		wr(8'ha9, 16'h00ff);
		rc(8'ha9, 16'h0b06, "locked write");
		@(posedge mclk) key_unlocked <= 1'b1;
		wr(8'ha8, 16'h802f);
		rc(8'ha8, 16'h800f, "fast before ready");
		wr(8'ha9, 16'hf0f8);
		rc(8'ha9, 16'h41f8, "control two");
		chk("trickle select", {15'h0, trickle_current_select_q}, 16'h1);
		chk("voltage select", {14'h0, termination_voltage_select_q}, 16'h3);
		chk("current select", {12'h0, fast_current_select_q}, 16'h8);
		wr(8'ha9, 16'h0f08);
		rc(8'ha9, 16'h0e08, "longest timeout");
		// Low cell on a good supply starts a trickle charge
		@(posedge mclk) cmd <= 7'h03;
		await(0, 1'b1, 100);
		rc(8'ha9, 16'h9e08, "trickle status");
		chk("fast", {15'h0, fast_on_q}, 16'h0);
		wr(8'ha9, 16'h4f08);
		await(0, 1'b0, 100);
		@(posedge mclk) sm_reset <= 1'b1;
		@(posedge mclk) sm_reset <= 1'b0;
		rd(8'ha9);
		chk("pause", {15'h0, d[14]}, 16'h0);
		await(0, 1'b1, 100);
		wr(8'ha8, 16'h003f);
		await(0, 1'b0, 100);
		// Ready seen, cell no longer low, USB source weak
		@(posedge mclk) cmd <= 7'h19;
		repeat (8) @(posedge mclk);
		wr(8'ha8, 16'h803f);
		await(1, 1'b1, 100);
		await(2, 1'b1, 100);
		rd(8'ha9);
		chk("fast status", {14'h0, d[13:12]}, 16'h2);
		// Throttle bit cleared: the weak source no longer throttles
		wr(8'ha8, 16'h802f);
		await(2, 1'b0, 100);
		wr(8'ha8, 16'h803f);
		await(2, 1'b1, 100);
		for (i = 0; i < 4; i++) begin
			@(posedge mclk) faults <= 4'h1 << i;
			await(0, 1'b0, 100);
			wr(8'ha8, 16'h803f & ~(16'h1 << i));
			await(0, 1'b1, 100);
			wr(8'ha8, 16'h803f);
			await(0, 1'b0, 100);
			@(posedge mclk) faults <= 4'h0;
			await(0, 1'b1, 100);
		end
		// Wall feedback on line power stops charging unless masked
		@(posedge mclk) cmd <= 7'h79;
		await(0, 1'b0, 100);
		wr(8'ha9, 16'h0f88);
		await(0, 1'b1, 100);
		// Supply loss stops charging; its return restarts it
		@(posedge mclk) cmd <= 7'h78;
		await(0, 1'b0, 100);
		@(posedge mclk) cmd <= 7'h19;
		await(0, 1'b1, 100);
		// Full cell with zero-current end action
		@(posedge mclk) cmd <= 7'h15;
		await(0, 1'b0, 100);
		rd(8'ha9);
		chk("mode after end", {14'h0, d[13:12]}, 16'h0);
		wr(8'ha8, 16'h003f);
		wr(8'ha9, 16'h0008);
		@(posedge mclk) cmd <= 7'h11;
		wr(8'ha8, 16'h807f);
		await(0, 1'b1, 100);
		// Keep charging past the full cell until the 60 minute timeout
		@(posedge mclk) cmd <= 7'h15;
		repeat (200) @(posedge mclk);
		chk("run to timeout", {15'h0, charge_on_q}, 16'h1);
		await(0, 1'b0, 37000);
		rd(8'ha9);
		chk("time left", {12'h0, d[11:8]}, 16'h0);
		report_and_stop();
	end
endmodule
